// [rtl/ocri_bank.sv]
// Summary of operation
// - any over-current fault sets status, alerts host
// - code 00 limits current indefinitely
// - code 01 limits while output voltage okay
// - code 01 low voltage shuts down, retries
// - code 10 limits for delay, then retries
// - code 11 disables until fault gone
// - retry 000 latches output off until clear
// - retry 001-101 gives one to five attempts
// - attempts spaced by delay field units
// - writable 12-character maker identity string
// - writable 20-character model string
// - writable 12-character revision string
// - writable 12-character location string
// - read returns 12-character build date
// - read returns 20-character serial in 160 bits
// - retry 110 gives six attempts, then off
// - delay field n selects 2^n units
`timescale 1ns/1ps
module ocri_bank #(
    parameter logic [95:0]  BUILD_DATE    = 96'h0,  // arbitrary value
    parameter logic [159:0] SERIAL_NUMBER = 160'h0  // arbitrary value
) (
    // clock and reset
    input  wire logic         CLK_I,
    input  wire logic         RSTN_I,
    // command port
    input  wire logic [7:0]   CMD_I,
    input  wire logic         WR_I,
    input  wire logic [159:0] WDATA_I,
    input  wire logic         RD_I,
    output logic      [159:0] RDATA_O,
    output logic      [7:0]   RCOUNT_O,
    output logic              RVALID_O,
    output logic              CMD_ERR_O,
    // converter status and commands
    input  wire logic         OUT_ON_I,
    input  wire logic         OC_FAULT_I,
    input  wire logic         VOUT_LOW_I,
    input  wire logic         FAULT_CLEAR_I,
    input  wire logic [15:0]  UNIT_CYCLES_I,
    // converter control and status
    output logic              OUT_EN_O,
    output logic              CUR_LIMIT_O,
    output logic              OC_FAULT_FLAG_O,
    output logic              HOST_ALERT_O,
    output logic              LATCHED_OFF_O,
    output logic      [2:0]   ATTEMPTS_O,
    output logic      [7:0]   OC_CONFIG_O
);

    typedef struct packed {
        ocri_pkg::ocri_seq_t st;
        logic [7:0]          cfg;
        logic [95:0]         maker;
        logic [159:0]        model;
        logic [95:0]         rev;
        logic [95:0]         loc;
        logic [159:0]        rdata;
        logic [7:0]          rcount;
        logic                rvalid;
        logic                cmd_err;
        logic                out_en;
        logic                cur_lim;
        logic                flag;
        logic                alert;
        logic                latched;
        logic                fault_d;
        logic [2:0]          attempts;
        logic                tmr_start;
        logic                tmr_abort;
    } ocri_bank_t;

    ocri_bank_t   q_ff;
    ocri_bank_t   nxt_q;
    ocri_delay_if dly ();

    // where a shutdown leads: another attempt or latched off
    function automatic ocri_pkg::ocri_seq_t after_shutdown(input logic [7:0] cfg,
                                                           input logic [2:0] tries);
        logic [2:0] budget;
        budget = cfg[ocri_pkg::RETRY_HI:ocri_pkg::RETRY_LO];
        if (budget == ocri_pkg::RETRY_NONE) begin
            after_shutdown = ocri_pkg::SEQ_LATCHED;
        end else if (budget == ocri_pkg::RETRY_FOREVER) begin
            after_shutdown = ocri_pkg::SEQ_SPACING;
        end else if (tries < budget) begin
            after_shutdown = ocri_pkg::SEQ_SPACING;
        end else begin
            after_shutdown = ocri_pkg::SEQ_LATCHED;
        end
    endfunction

    // widen a short string to the read data width
    function automatic logic [159:0] widen(input logic [95:0] s);
        widen = {64'h0, s};
    endfunction

    // delay timer, shared by the limit delay and the retry spacing
    assign dly.start       = q_ff.tmr_start;
    assign dly.abort       = q_ff.tmr_abort;
    assign dly.exp         = q_ff.cfg[ocri_pkg::DELAY_HI:ocri_pkg::DELAY_LO];
    assign dly.unit_cycles = UNIT_CYCLES_I;

    ocri_delay_timer u_timer (
        .clk_i  (CLK_I),
        .rstn_i (RSTN_I),
        .dly    (dly.timer)
    );

    // next state: command port, fault flags and retry sequencer
    always_comb begin
        nxt_q = q_ff;
        nxt_q.rvalid    = 1'b0;
        nxt_q.cmd_err   = 1'b0;
        nxt_q.tmr_start = 1'b0;
        nxt_q.tmr_abort = 1'b0;
        nxt_q.fault_d   = OC_FAULT_I;

        // writes: read-only and unknown codes are refused and flagged
        if (WR_I) begin
            case (CMD_I)
                ocri_pkg::CMD_MAKER_ID: begin
                    nxt_q.maker = WDATA_I[95:0];
                end
                ocri_pkg::CMD_MODEL: begin
                    nxt_q.model = WDATA_I;
                end
                ocri_pkg::CMD_REVISION: begin
                    nxt_q.rev = WDATA_I[95:0];
                end
                ocri_pkg::CMD_LOCATION: begin
                    nxt_q.loc = WDATA_I[95:0];
                end
                ocri_pkg::CMD_OC_REACTION: begin
                    nxt_q.cfg = WDATA_I[7:0];
                end
                default: begin
                    nxt_q.cmd_err = 1'b1;
                end
            endcase
        end

        // reads return the stored value and its byte count
        if (RD_I) begin
            nxt_q.rvalid = 1'b1;
            case (CMD_I)
                ocri_pkg::CMD_MAKER_ID: begin
                    nxt_q.rdata  = widen(q_ff.maker);
                    nxt_q.rcount = ocri_pkg::SHORT_BYTES;
                end
                ocri_pkg::CMD_MODEL: begin
                    nxt_q.rdata  = q_ff.model;
                    nxt_q.rcount = ocri_pkg::LONG_BYTES;
                end
                ocri_pkg::CMD_REVISION: begin
                    nxt_q.rdata  = widen(q_ff.rev);
                    nxt_q.rcount = ocri_pkg::SHORT_BYTES;
                end
                ocri_pkg::CMD_LOCATION: begin
                    nxt_q.rdata  = widen(q_ff.loc);
                    nxt_q.rcount = ocri_pkg::SHORT_BYTES;
                end
                ocri_pkg::CMD_BUILD_DATE: begin
                    nxt_q.rdata  = widen(BUILD_DATE);
                    nxt_q.rcount = ocri_pkg::SHORT_BYTES;
                end
                ocri_pkg::CMD_SERIAL: begin
                    nxt_q.rdata  = SERIAL_NUMBER;
                    nxt_q.rcount = ocri_pkg::LONG_BYTES;
                end
                ocri_pkg::CMD_OC_REACTION: begin
                    nxt_q.rdata  = {152'h0, q_ff.cfg};
                    nxt_q.rcount = ocri_pkg::CFG_BYTES;
                end
                default: begin
                    nxt_q.rdata   = ocri_pkg::STR_RESET;
                    nxt_q.rcount  = 8'h00;
                    nxt_q.cmd_err = 1'b1;
                end
            endcase
        end

        // sticky fault flag and alert; a new fault beats a clear in the same cycle
        if (FAULT_CLEAR_I) begin
            nxt_q.flag  = 1'b0;
            nxt_q.alert = 1'b0;
        end
        if (OC_FAULT_I) begin
            nxt_q.flag = 1'b1;
        end
        if (OC_FAULT_I && !q_ff.fault_d) begin
            nxt_q.alert = 1'b1;
        end

        // retry sequencer
        case (q_ff.st)
            ocri_pkg::SEQ_OFF: begin
                if (OUT_ON_I) begin
                    nxt_q.st = ocri_pkg::SEQ_RUN;
                end
            end
            ocri_pkg::SEQ_RUN: begin
                if (OC_FAULT_I) begin
                    case (q_ff.cfg[ocri_pkg::RESP_HI:ocri_pkg::RESP_LO])
                        ocri_pkg::RESP_CC: begin
                            nxt_q.st = ocri_pkg::SEQ_LIMIT;
                        end
                        ocri_pkg::RESP_COND: begin
                            nxt_q.st = ocri_pkg::SEQ_LIMIT;
                        end
                        ocri_pkg::RESP_DELAY: begin
                            nxt_q.st        = ocri_pkg::SEQ_DELAY;
                            nxt_q.tmr_start = 1'b1;
                        end
                        default: begin
                            nxt_q.st = ocri_pkg::SEQ_HOLD_OFF;
                        end
                    endcase
                end
            end
            ocri_pkg::SEQ_LIMIT: begin
                // under code 00 the output voltage is not looked at
                if (!OC_FAULT_I) begin
                    nxt_q.st = ocri_pkg::SEQ_RUN;
                end else if (q_ff.cfg[ocri_pkg::RESP_HI:ocri_pkg::RESP_LO] ==
                             ocri_pkg::RESP_COND && VOUT_LOW_I) begin
                    nxt_q.st        = after_shutdown(q_ff.cfg, q_ff.attempts);
                    nxt_q.tmr_start = 1'b1;
                end
            end
            ocri_pkg::SEQ_DELAY: begin
                if (!OC_FAULT_I) begin
                    nxt_q.st        = ocri_pkg::SEQ_RUN;
                    nxt_q.tmr_abort = 1'b1;
                end else if (dly.done) begin
                    nxt_q.st        = after_shutdown(q_ff.cfg, q_ff.attempts);
                    nxt_q.tmr_start = 1'b1;
                end
            end
            ocri_pkg::SEQ_SPACING: begin
                // output off; the attempt starts when the spacing delay ends
                if (dly.done) begin
                    nxt_q.st = ocri_pkg::SEQ_RUN;
                    if (q_ff.attempts != 3'h7) begin
                        nxt_q.attempts = q_ff.attempts + 3'h1;
                    end
                end
            end
            ocri_pkg::SEQ_LATCHED: begin
                if (FAULT_CLEAR_I) begin
                    nxt_q.st = ocri_pkg::SEQ_RUN;
                end
            end
            ocri_pkg::SEQ_HOLD_OFF: begin
                if (!OC_FAULT_I) begin
                    nxt_q.st = ocri_pkg::SEQ_RUN;
                end
            end
            default: begin
                nxt_q.st = ocri_pkg::SEQ_OFF;
            end
        endcase

        // a fresh budget after a clear or an off; after the sequencer so a spacing step cannot undo it
        if (FAULT_CLEAR_I || !OUT_ON_I) begin
            nxt_q.attempts = 3'h0;
        end

        // an off command overrides every response
        if (!OUT_ON_I) begin
            nxt_q.st        = ocri_pkg::SEQ_OFF;
            nxt_q.tmr_abort = q_ff.st != ocri_pkg::SEQ_OFF;
            nxt_q.tmr_start = 1'b0;
        end

        // the timer is started only on the way into a timed state
        if (nxt_q.st != ocri_pkg::SEQ_DELAY && nxt_q.st != ocri_pkg::SEQ_SPACING) begin
            nxt_q.tmr_start = 1'b0;
        end

        // output drive follows the next state so the pins stay registered
        nxt_q.out_en  = nxt_q.st == ocri_pkg::SEQ_RUN || nxt_q.st == ocri_pkg::SEQ_LIMIT ||
                        nxt_q.st == ocri_pkg::SEQ_DELAY;
        nxt_q.cur_lim = nxt_q.st == ocri_pkg::SEQ_LIMIT || nxt_q.st == ocri_pkg::SEQ_DELAY;
        nxt_q.latched = nxt_q.st == ocri_pkg::SEQ_LATCHED;
    end

    // state register; strings come up empty
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            q_ff     <= '0;
            q_ff.st  <= ocri_pkg::SEQ_OFF;
            q_ff.cfg <= ocri_pkg::OCR_RESET;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // outputs straight from the state register
    assign RDATA_O         = q_ff.rdata;
    assign RCOUNT_O        = q_ff.rcount;
    assign RVALID_O        = q_ff.rvalid;
    assign CMD_ERR_O       = q_ff.cmd_err;
    assign OUT_EN_O        = q_ff.out_en;
    assign CUR_LIMIT_O     = q_ff.cur_lim;
    assign OC_FAULT_FLAG_O = q_ff.flag;
    assign HOST_ALERT_O    = q_ff.alert;
    assign LATCHED_OFF_O   = q_ff.latched;
    assign ATTEMPTS_O      = q_ff.attempts;
    assign OC_CONFIG_O     = q_ff.cfg;

endmodule

// [rtl/ocri_pkg.sv]
package ocri_pkg;

    // command codes of the register bank
    localparam logic [7:0] CMD_MAKER_ID    = 8'h99;
    localparam logic [7:0] CMD_MODEL       = 8'h9a;
    localparam logic [7:0] CMD_REVISION    = 8'h9b;
    localparam logic [7:0] CMD_LOCATION    = 8'h9c;
    localparam logic [7:0] CMD_BUILD_DATE  = 8'h9d;
    localparam logic [7:0] CMD_SERIAL      = 8'h9e;
    localparam logic [7:0] CMD_OC_REACTION = 8'hb8;

    // string widths and their byte counts
    localparam int         SHORT_W     = 96;
    localparam int         LONG_W      = 160;
    localparam logic [7:0] SHORT_BYTES = 8'h0c;
    localparam logic [7:0] LONG_BYTES  = 8'h14;
    localparam logic [7:0] CFG_BYTES   = 8'h01;

    // field layout of the over-current reaction byte
    localparam int RESP_HI  = 7;
    localparam int RESP_LO  = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;

    // response and retry encodings
    localparam logic [1:0] RESP_CC      = 2'h0;
    localparam logic [1:0] RESP_COND    = 2'h1;
    localparam logic [1:0] RESP_DELAY   = 2'h2;
    localparam logic [1:0] RESP_DISABLE = 2'h3;
    localparam logic [2:0] RETRY_NONE    = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // reset values
    localparam logic [7:0]   OCR_RESET = 8'h00;
    localparam logic [159:0] STR_RESET = 160'h0;

    // delay timer sizing: unit length in clocks, units up to 2^7
    localparam int UNIT_W  = 16;
    localparam int UNITS_W = 9;

    // retry sequencer states
    typedef enum logic [2:0] {
        SEQ_OFF,
        SEQ_RUN,
        SEQ_LIMIT,
        SEQ_DELAY,
        SEQ_SPACING,
        SEQ_LATCHED,
        SEQ_HOLD_OFF
    } ocri_seq_t;

endpackage

// [rtl/ocri_delay_if.sv]
`timescale 1ns/1ps
// delay request from the sequencer to the delay timer
interface ocri_delay_if;
    logic                        start;
    logic                        abort;
    logic [2:0]                  exp;
    logic [ocri_pkg::UNIT_W-1:0] unit_cycles;
    logic                        busy;
    logic                        done;

    modport timer (
        input  start,
        input  abort,
        input  exp,
        input  unit_cycles,
        output busy,
        output done
    );

    modport ctrl (
        output start,
        output abort,
        output exp,
        output unit_cycles,
        input  busy,
        input  done
    );
endinterface

// [rtl/ocri_delay_timer.sv]
`timescale 1ns/1ps
// counts 2^exp delay units, each unit_cycles clocks long
module ocri_delay_timer (
    input wire logic         clk_i,
    input wire logic         rstn_i,
    ocri_delay_if.timer      dly
);

    typedef struct packed {
        logic                         busy;
        logic                         done;
        logic [ocri_pkg::UNIT_W-1:0]  div;
        logic [ocri_pkg::UNITS_W-1:0] units;
        logic [ocri_pkg::UNITS_W-1:0] target;
    } ocri_tmr_t;

    ocri_tmr_t q_ff;
    ocri_tmr_t nxt_q;
    logic      tick;

    // a unit length of zero is treated as one clock so the timer cannot hang
    always_comb begin
        tick = (q_ff.div + 16'h0001 >= dly.unit_cycles);
        nxt_q = q_ff;
        nxt_q.done = 1'b0;
        if (dly.abort) begin
            nxt_q.busy = 1'b0;
        end else if (dly.start) begin
            nxt_q.busy   = 1'b1;
            nxt_q.div    = 16'h0000;
            nxt_q.units  = 9'h000;
            nxt_q.target = 9'h001 << dly.exp;
        end else if (q_ff.busy) begin
            if (tick) begin
                nxt_q.div   = 16'h0000;
                nxt_q.units = q_ff.units + 9'h001;
                if (q_ff.units + 9'h001 == q_ff.target) begin
                    nxt_q.busy = 1'b0;
                    nxt_q.done = 1'b1;
                end
            end else begin
                nxt_q.div = q_ff.div + 16'h0001;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign dly.busy = q_ff.busy;
    assign dly.done = q_ff.done;

endmodule

// [tb/ocri_host_model.sv]
`timescale 1ns/1ps
// host side of the command port: one strobe per access, whole value per access
module ocri_host_model (
    // clock
    input  wire logic         clk_i,
    // command port toward the bank
    output logic      [7:0]   cmd_o,
    output logic              wr_o,
    output logic      [159:0] wdata_o,
    output logic              rd_o
);
    // quiet bus at time zero
    initial begin
        cmd_o   = 8'h00;
        wr_o    = 1'b0;
        wdata_o = 160'h0;
        rd_o    = 1'b0;
    end

    // request held for exactly one sampling edge, answer taken by the caller after it
    task automatic access(input logic w, input logic [7:0] cmd, input logic [159:0] data);
        @(posedge clk_i);
        cmd_o   <= cmd;
        wdata_o <= data;
        wr_o    <= w;
        rd_o    <= !w;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        rd_o    <= 1'b0;
        // idle lines carry the inverse so a stale value cannot pass for a fresh one
        cmd_o   <= ~cmd;
        wdata_o <= ~data;
    endtask
endmodule

// [tb/ocri_bank_assertions.sv]
`timescale 1ns/1ps
module ocri_bank_assertions (
    // clock and reset
    input wire logic       CLK_I,
    input wire logic       RSTN_I,
    // command port
    input wire logic [7:0] CMD_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RCOUNT_O,
    input wire logic       RVALID_O,
    input wire logic       CMD_ERR_O,
    // converter side
    input wire logic       OUT_ON_I,
    input wire logic       OC_FAULT_I,
    input wire logic       VOUT_LOW_I,
    input wire logic       FAULT_CLEAR_I,
    input wire logic       OUT_EN_O,
    input wire logic       CUR_LIMIT_O,
    input wire logic       OC_FAULT_FLAG_O,
    input wire logic       LATCHED_OFF_O,
    input wire logic [2:0] ATTEMPTS_O,
    input wire logic [7:0] OC_CONFIG_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    // mode decode; a write in flight may change it, so guards below exclude WR_I
    wire [1:0] mode = OC_CONFIG_O[7:6];

    read_answer_a: assert property (
        RD_I |=> RVALID_O) else $error("read got no answer");
    short_count_a: assert property (
        RD_I && CMD_I inside {8'h99, 8'h9b, 8'h9c, 8'h9d} |=> RCOUNT_O == 8'h0c)
        else $error("short string count wrong");
    ro_write_a: assert property (
        WR_I && CMD_I inside {8'h9d, 8'h9e} |=> CMD_ERR_O) else $error("read-only write taken");
    flag_set_a: assert property (
        OC_FAULT_I |=> OC_FAULT_FLAG_O) else $error("fault flag not set");
    off_clears_a: assert property (
        !OUT_ON_I |=> !OUT_EN_O && ATTEMPTS_O == 3'h0) else $error("off did not clear");
    cc_keeps_a: assert property (
        OUT_EN_O && OUT_ON_I && mode == 2'h0 && !WR_I |=> OUT_EN_O)
        else $error("limiting mode dropped output");
    hold_off_a: assert property (
        OC_FAULT_I && OUT_ON_I && mode == 2'h3 && !WR_I |=> !OUT_EN_O)
        else $error("output on during fault");
    resume_ok_a: assert property (
        OUT_ON_I && !OC_FAULT_I && mode == 2'h3 && !LATCHED_OFF_O && !WR_I |-> ##[1:2] OUT_EN_O)
        else $error("output did not resume");
    cond_shut_a: assert property (
        mode == 2'h1 && CUR_LIMIT_O && VOUT_LOW_I && OUT_ON_I && !WR_I |=> !OUT_EN_O)
        else $error("no shutdown at low voltage");
    latch_hold_a: assert property (
        LATCHED_OFF_O && OUT_ON_I && !FAULT_CLEAR_I |=> LATCHED_OFF_O && !OUT_EN_O)
        else $error("latched off left early");
endmodule

bind ocri_bank ocri_bank_assertions ocri_bank_assertions_i (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .CMD_I(CMD_I), .WR_I(WR_I), .RD_I(RD_I),
    .RCOUNT_O(RCOUNT_O), .RVALID_O(RVALID_O), .CMD_ERR_O(CMD_ERR_O), .OUT_ON_I(OUT_ON_I),
    .OC_FAULT_I(OC_FAULT_I), .VOUT_LOW_I(VOUT_LOW_I), .FAULT_CLEAR_I(FAULT_CLEAR_I),
    .OUT_EN_O(OUT_EN_O), .CUR_LIMIT_O(CUR_LIMIT_O), .OC_FAULT_FLAG_O(OC_FAULT_FLAG_O),
    .LATCHED_OFF_O(LATCHED_OFF_O), .ATTEMPTS_O(ATTEMPTS_O), .OC_CONFIG_O(OC_CONFIG_O));

// [tb/overcurrent_fault_response_info_test.sv]
`timescale 1ns/1ps
module overcurrent_fault_response_info_test;
    typedef struct packed {
        logic [7:0]   cmd;
        logic [159:0] wd;
        logic [159:0] rd;
        logic [7:0]   cnt;
        logic         err;
    } ocri_row_t;
    localparam logic [95:0]  DATE_V = 96'h303130323033;     // arbitrary value
    localparam logic [159:0] SER_V  = 160'h4131323334353637; // arbitrary value
    localparam logic [159:0] HI_V   = {64'hffffffffffffffff, 96'h0};
    // stimulus
    logic         clk = 1'b0;
    logic         rstn = 1'b0;
    logic         out_on = 1'b0;
    logic         oc_fault = 1'b0;
    logic         vout_low = 1'b0;
    logic         fault_clr = 1'b0;
    logic [15:0]  unit_cyc = 16'h0001;
    logic [7:0]   cmd;
    logic         wr;
    logic         rd;
    logic [159:0] wdata;
    // observed outputs
    logic [159:0] rdata;
    logic [7:0]   rcount;
    logic [7:0]   cfg;
    logic [2:0]   attempts;
    logic         rvalid, cmd_err, out_en, cur_lim, oc_flag, alert, latched;
    int           miscompares = 0;
    int           num_checks = 0;
    int           cyc = 0;
    int           rs, c;
    // short strings keep only 96 bits, so upper write bits must not come back
    ocri_row_t rows [8] = '{
        '{8'h99, HI_V | 160'h4d414b4552, 160'h4d414b4552, 8'h0c, 1'b0},
        '{8'h9a, {32'h4d4f4445, 128'h4c2d31}, {32'h4d4f4445, 128'h4c2d31}, 8'h14, 1'b0},
        '{8'h9b, HI_V | 160'h524556, 160'h524556, 8'h0c, 1'b0},
        '{8'h9c, 160'h4c4f43, 160'h4c4f43, 8'h0c, 1'b0},
        '{8'h9d, 160'h11, 160'(DATE_V), 8'h0c, 1'b1},
        '{8'h9e, 160'h22, SER_V, 8'h14, 1'b1},
        '{8'hb8, 160'h5b, 160'h5b, 8'h01, 1'b0},
        '{8'h50, 160'h33, 160'h0, 8'h00, 1'b1}
    };

    ocri_host_model ocri_host_model_i (.clk_i(clk), .cmd_o(cmd), .wr_o(wr), .wdata_o(wdata),
        .rd_o(rd));

    ocri_bank #(.BUILD_DATE(DATE_V), .SERIAL_NUMBER(SER_V)) ocri_bank_i (
        .CLK_I(clk), .RSTN_I(rstn), .CMD_I(cmd), .WR_I(wr), .WDATA_I(wdata), .RD_I(rd),
        .RDATA_O(rdata), .RCOUNT_O(rcount), .RVALID_O(rvalid), .CMD_ERR_O(cmd_err),
        .OUT_ON_I(out_on), .OC_FAULT_I(oc_fault), .VOUT_LOW_I(vout_low),
        .FAULT_CLEAR_I(fault_clr), .UNIT_CYCLES_I(unit_cyc), .OUT_EN_O(out_en),
        .CUR_LIMIT_O(cur_lim), .OC_FAULT_FLAG_O(oc_flag), .HOST_ALERT_O(alert),
        .LATCHED_OFF_O(latched), .ATTEMPTS_O(attempts), .OC_CONFIG_O(cfg));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    // hang guard, far above the fewer than a thousand cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic check(input logic [159:0] seen, input logic [159:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // let n edges pass, then sample once their updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic set_cfg(input logic [7:0] v);
        ocri_host_model_i.access(1'b1, 8'hb8, 160'(v));
    endtask

    task automatic clear_fault;
        @(posedge clk);
        oc_fault  <= 1'b0;
        vout_low  <= 1'b0;
        fault_clr <= 1'b1;
        @(posedge clk);
        fault_clr <= 1'b0;
        tick(4);
    endtask

    // counts cycles until the output enable reaches lvl, bounded
    task automatic wait_en(input logic lvl, output int n);
        n = 0;
        do begin
            tick(1);
            n++;
        end while (out_en !== lvl && n < 100);
    endtask

    // raises the fault under cfg and counts restarts until latched off or lim cycles
    task automatic run_fault(input logic [7:0] v, input int lim, output int n);
        logic prev;
        n = 0;
        prev = 1'b1;
        set_cfg(v);
        @(posedge clk) oc_fault <= 1'b1;
        repeat (lim) begin
            tick(1);
            if (out_en === 1'b1 && !prev)
                n++;
            prev = out_en;
            if (latched === 1'b1)
                break;
        end
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rstn   <= 1'b1;
        out_on <= 1'b1;
        // every command: write, then read back
        foreach (rows[i]) begin
            ocri_host_model_i.access(1'b1, rows[i].cmd, rows[i].wd);
            #1;
            check(160'(cmd_err), 160'(rows[i].err));
            ocri_host_model_i.access(1'b0, rows[i].cmd, 160'h0);
            #1;
            check(160'(rvalid), 160'h1);
            check(rdata, rows[i].rd);
            check(160'(rcount), 160'(rows[i].cnt));
        end
        // every finite retry count, shortest delay
        for (int r = 0; r < 7; r++) begin
            run_fault({2'h2, 3'(r), 3'h0}, 2000, rs);
            check(160'(rs), 160'(r));
            check({oc_flag, alert, latched, out_en}, 160'he);
            clear_fault();
            check({out_en, attempts}, 160'h8);
        end
        // delay field 3 gives 8 units of 2 cycles, for limiting and for spacing
        @(posedge clk) unit_cyc <= 16'h0002;
        set_cfg(8'h8b);
        #1;
        check(160'(cfg), 160'h8b);
        @(posedge clk) oc_fault <= 1'b1;
        wait_en(1'b0, c);
        check(160'(c >= 16 && c <= 22), 160'h1);
        wait_en(1'b1, c);
        check(160'(c >= 16 && c <= 22), 160'h1);
        check(160'(attempts), 160'h1);
        clear_fault();
        @(posedge clk) unit_cyc <= 16'h0001;
        // endless retries stop only when commanded off
        run_fault(8'hb8, 300, rs);
        check({latched, 159'(rs > 7)}, 160'h1);
        @(posedge clk) out_on <= 1'b0;
        tick(2);
        check({out_en, attempts}, 160'h0);
        @(posedge clk) out_on <= 1'b1;
        clear_fault();
        // plain limiting ignores the output voltage
        set_cfg(8'h00);
        @(posedge clk) oc_fault <= 1'b1;
        vout_low <= 1'b1;
        tick(40);
        check({out_en, cur_lim, latched}, 160'h6);
        clear_fault();
        // conditional limiting until the output sags
        set_cfg(8'h40);
        @(posedge clk) oc_fault <= 1'b1;
        tick(20);
        check({out_en, cur_lim, latched}, 160'h6);
        @(posedge clk) vout_low <= 1'b1;
        tick(4);
        check({out_en, latched}, 160'h1);
        clear_fault();
        // output off only while the fault stays
        set_cfg(8'hc0);
        @(posedge clk) oc_fault <= 1'b1;
        tick(3);
        check({out_en, latched}, 160'h0);
        @(posedge clk) oc_fault <= 1'b0;
        tick(3);
        check(160'(out_en), 160'h1);
        // second reset in mid-run clears state and strings
        @(posedge clk) rstn <= 1'b0;
        tick(2);
        check({cfg, out_en, oc_flag, alert, attempts}, 160'h0);
        @(posedge clk) rstn <= 1'b1;
        ocri_host_model_i.access(1'b0, 8'h99, 160'h0);
        #1;
        check(rdata, 160'h0);
        test_done();
    end
endmodule
